// ---- logic/wtp_pkg.sv ----
/*
 * Shared constants for the watch tick prescaler: register map, field
 * positions, reset values, tap tables and timing figures.
 * Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz system clock.
 */
package wtp_pkg;

    // ----------
    // Bus geometry
    // ----------
    localparam int          AXI_AW        = 8;
    localparam int          AXI_DW        = 32;
    localparam int          AXI_SW        = AXI_DW / 8;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ----------
    // Register offsets (byte addresses)
    // ----------
    localparam logic [AXI_AW-1:0] OFS_SRC_TAP_SEL = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_RUN_CTRL    = 8'h04;

    // ----------
    // Field positions
    // ----------
    localparam int          SRC_SEL_LSB   = 0;
    localparam int          SRC_SEL_W     = 2;
    localparam int          TAP_SET_LSB   = 8;
    localparam int          TAP_SET_W     = 3;
    localparam int          RUN_EN_BIT    = 0;
    localparam int          RUN_STATE_BIT = 1;

    // Writable field masks per variant
    localparam logic [SRC_SEL_W-1:0] SRC_MASK_A = 2'h1;
    localparam logic [SRC_SEL_W-1:0] SRC_MASK_B = 2'h3;
    localparam logic [TAP_SET_W-1:0] TAP_MASK_A = 3'h1;
    localparam logic [TAP_SET_W-1:0] TAP_MASK_B = 3'h7;

    // Reset values
    localparam logic [SRC_SEL_W-1:0] SRC_SEL_RST = 2'h0;
    localparam logic [TAP_SET_W-1:0] TAP_SET_RST = 3'h0;
    localparam logic                 RUN_EN_RST  = 1'b0;

    // Source select codes
    localparam logic [SRC_SEL_W-1:0] SRC_SUB     = 2'h0;
    localparam logic [SRC_SEL_W-1:0] SRC_MAIN    = 2'h1;
    localparam logic [SRC_SEL_W-1:0] SRC_FAST_RC = 2'h2;
    localparam logic [SRC_SEL_W-1:0] SRC_SLOW_RC = 2'h3;
    localparam int                   SRC_N       = 4;

    // ----------
    // Divider and tap table: counter bit feeding tick 0 for each code;
    // tick k uses that bit plus k (period 2^(bit+1) source cycles)
    // ----------
    localparam int          CNT_W         = 25;
    localparam int          TICK_N        = 4;
    localparam logic [4:0]  TAP_BASE_000  = 5'h0B;
    localparam logic [4:0]  TAP_BASE_001  = 5'h15;
    localparam logic [4:0]  TAP_BASE_010  = 5'h00;
    localparam logic [4:0]  TAP_BASE_011  = 5'h04;
    localparam logic [4:0]  TAP_BASE_100  = 5'h08;
    localparam logic [4:0]  TAP_BASE_101  = 5'h0F;
    localparam logic [4:0]  TAP_BASE_110  = 5'h13;

    // ----------
    // Timing
    // ----------
    localparam int          SYS_CLK_PERIOD_NS = 40;
    localparam int          EN_LAT_SRC_CYC    = 2;
    localparam int          RST_SYNC_STAGES   = 2;

endpackage

// ---- logic/wtp_pin_sync.sv ----
/*
 * Three-flop input synchroniser for asynchronous pins.
 * The output follows only once the second and third stage agree.
 * Assumes a single sampling clock and an active-low async reset.
 */
`timescale 1ns/10ps
module wtp_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_i,   // Sampling clock
    input  wire logic         rst_n_i,     // Active-low reset
    input  wire logic [W-1:0] pin_i,       // Asynchronous inputs
    output logic      [W-1:0] sync_o       // Filtered synchronous copy
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    // ----------
    // Stage chain; first stage is read only by the second
    // ----------
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            sync_o <= '0;
        end
        else
        begin
            s1_q   <= pin_i;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            sync_o <= (agree & s3_q) | (~agree & sync_o);
        end
    end

endmodule // wtp_pin_sync

// ---- logic/wtp_tap_mux.sv ----
/*
 * Tap selection for the four tick outputs: picks counter bits per the
 * tap-set code and blanks all ticks for the undefined code.
 * Assumes the caller masks the code to the variant's legal range.
 */
`timescale 1ns/10ps
module wtp_tap_mux
    import wtp_pkg::*;
(
    input  wire logic [wtp_pkg::CNT_W-1:0]     cnt_i,     // Divider count
    input  wire logic [wtp_pkg::TAP_SET_W-1:0] tap_set_i, // Tap-set code
    output logic      [wtp_pkg::TICK_N-1:0]    tick_o     // Selected tick levels
);

    logic [4:0] base;
    logic       tap_ok;

    // ----------
    // Code to base bit decode
    // ----------
    always_comb
    begin
        tap_ok = 1'b1;
        case (tap_set_i)
            3'h0:    base = TAP_BASE_000;   // RL1 RL10
            3'h1:    base = TAP_BASE_001;   // RL1 RL10
            3'h2:    base = TAP_BASE_010;   // RL10
            3'h3:    base = TAP_BASE_011;   // RL10
            3'h4:    base = TAP_BASE_100;   // RL11
            3'h5:    base = TAP_BASE_101;   // RL11
            3'h6:    base = TAP_BASE_110;   // RL11
            default:
            begin
                base   = 5'h00;
                tap_ok = 1'b0;              // RL22
            end
        endcase
    end

    // One bit pick per tick
    genvar k;
    generate
        for (k = 0; k < TICK_N; k++)
        begin : g_tick
            logic [4:0] idx;
            assign idx       = base + 5'(k);
            assign tick_o[k] = tap_ok & cnt_i[idx];   // RL13
        end
    endgenerate

endmodule // wtp_tap_mux

// ---- logic/wtp_top.sv ----
/*
 * Watch tick prescaler: AXI4-Lite register slave, source clock selection,
 * down-counting divider and four tick outputs for a watch counter.
 * Assumes source clocks arrive as asynchronous pins no faster than a quarter of the
 * system clock; they are sampled, not used as clocks.
 */
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps

// Operation
// RL1 - Variant A tap bit picks two period sets
// RL2 - Variant A source bit: sub or main clock
// RL3 - Variant A unused select bits read zero
// RL4 - Software writes zero to select bits 10:9
// RL5 - Enable register bits 7:2 read zero
// RL6 - Bit 1 reads real run state, write-ignored
// RL7 - Enable low stops, blanks and clears counter
// RL8 - Enable high starts counting and toggling ticks
// RL9 - Enable lands two source cycles after write
// RL10 - Variant B codes 000 to 011 periods
// RL11 - Variant B codes 100 to 110 periods
// RL12 - Variant B offers four divider sources
// RL13 - Down counter bits feed ticks via taps
// RL14 - Ticks held low while divider stopped
// RL15 - Register writes taken on bus clock edge
// RL16 - Bus settings synchronised before source use
// RL17 - Stop, poll, reselect, then re-enable
// RL18 - No changes while watch counter runs
// RL19 - Restart watch counter after re-enable
// RL20 - Variant B field positions and reserved bits
// RL21 - Variant B source code encoding
// RL22 - Variant parameter; code 111 holds ticks low
// RL23 - Select resets zero; two-stage enable crossing
module wtp_top
    import wtp_pkg::*;
#(
    parameter bit VARIANT_B = 1'b0                          // 0: variant A, 1: variant B
) (
    input  wire logic                          clk_sys_i,        // System clock, 25 MHz
    input  wire logic                          rst_n_i,          // Async reset, active low
    input  wire logic [wtp_pkg::AXI_AW-1:0]    s_axi_awaddr_i,   // Write address
    input  wire logic                          s_axi_awvalid_i,  // Write address valid
    output logic                               s_axi_awready_o,  // Write address ready
    input  wire logic [wtp_pkg::AXI_DW-1:0]    s_axi_wdata_i,    // Write data
    input  wire logic [wtp_pkg::AXI_SW-1:0]    s_axi_wstrb_i,    // Write byte strobes
    input  wire logic                          s_axi_wvalid_i,   // Write data valid
    output logic                               s_axi_wready_o,   // Write data ready
    output logic [1:0]                         s_axi_bresp_o,    // Write response
    output logic                               s_axi_bvalid_o,   // Write response valid
    input  wire logic                          s_axi_bready_i,   // Write response ready
    input  wire logic [wtp_pkg::AXI_AW-1:0]    s_axi_araddr_i,   // Read address
    input  wire logic                          s_axi_arvalid_i,  // Read address valid
    output logic                               s_axi_arready_o,  // Read address ready
    output logic [wtp_pkg::AXI_DW-1:0]         s_axi_rdata_o,    // Read data
    output logic [1:0]                         s_axi_rresp_o,    // Read response
    output logic                               s_axi_rvalid_o,   // Read data valid
    input  wire logic                          s_axi_rready_i,   // Read data ready
    input  wire logic                          src_sub_i,        // Sub clock pin
    input  wire logic                          src_main_i,       // Main clock pin
    input  wire logic                          src_fast_rc_i,    // Fast RC oscillator pin
    input  wire logic                          src_slow_rc_i,    // Prescaled slow RC pin
    output logic                               tick_out_0_o,     // Tick 0, shortest period
    output logic                               tick_out_1_o,     // Tick 1
    output logic                               tick_out_2_o,     // Tick 2
    output logic                               tick_out_3_o      // Tick 3, longest period
);

    // ----------
    // Declarations
    // ----------
    logic [RST_SYNC_STAGES-1:0] rst_pipe_q;
    logic                       rst_sync_n;

    logic                       awready_q;
    logic                       wready_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       arready_q;
    logic                       rvalid_q;
    logic [1:0]                 rresp_q;
    logic [AXI_DW-1:0]          rdata_q;
    logic [AXI_AW-1:0]          awaddr_q;
    logic [AXI_DW-1:0]          wdata_q;
    logic [AXI_SW-1:0]          wstrb_q;
    logic                       aw_have_q;
    logic                       w_have_q;

    logic [SRC_SEL_W-1:0]       src_sel_q;
    logic [TAP_SET_W-1:0]       tap_set_q;
    logic                       run_en_q;

    logic [SRC_N-1:0]           src_pins;
    logic [SRC_N-1:0]           src_sync;
    logic [SRC_N-1:0]           src_prev_q;
    logic [EN_LAT_SRC_CYC-1:0]  en_pipe_q;
    logic                       run_q;
    logic [CNT_W-1:0]           cnt_q;
    logic [TICK_N-1:0]          tick_nxt;
    logic [TICK_N-1:0]          tick_q;

    logic [SRC_SEL_W-1:0]       src_mask;
    logic [TAP_SET_W-1:0]       tap_mask;
    logic                       aw_hs;
    logic                       w_hs;
    logic                       ar_hs;
    logic                       do_wr;
    logic                       wr_sel_hit;
    logic                       wr_run_hit;
    logic                       wr_ok;
    logic                       rd_sel_hit;
    logic                       rd_run_hit;
    logic [AXI_DW-1:0]          rd_word;
    logic                       src_edge;

    // ----------
    // Reset release
    // ----------
    // Async assert, two-flop synchronous release
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_pipe_q <= '0;
        else
            rst_pipe_q <= {rst_pipe_q[RST_SYNC_STAGES-2:0], 1'b1};
    end

    assign rst_sync_n = rst_pipe_q[RST_SYNC_STAGES-1];

    // ----------
    // Bus decode
    // ----------
    // Writable bits depend on the build variant
    assign src_mask   = VARIANT_B ? SRC_MASK_B : SRC_MASK_A;  // RL22
    assign tap_mask   = VARIANT_B ? TAP_MASK_B : TAP_MASK_A;  // RL22

    assign aw_hs      = s_axi_awvalid_i & awready_q;
    assign w_hs       = s_axi_wvalid_i & wready_q;
    assign ar_hs      = s_axi_arvalid_i & arready_q;
    assign do_wr      = aw_have_q & w_have_q & ~bvalid_q;
    assign wr_sel_hit = (awaddr_q[AXI_AW-1:2] == OFS_SRC_TAP_SEL[AXI_AW-1:2]);
    assign wr_run_hit = (awaddr_q[AXI_AW-1:2] == OFS_RUN_CTRL[AXI_AW-1:2]);
    assign wr_ok      = wr_sel_hit | wr_run_hit;
    assign rd_sel_hit = (s_axi_araddr_i[AXI_AW-1:2] == OFS_SRC_TAP_SEL[AXI_AW-1:2]);
    assign rd_run_hit = (s_axi_araddr_i[AXI_AW-1:2] == OFS_RUN_CTRL[AXI_AW-1:2]);

    // Read words; every unlisted bit reads zero
    assign rd_word = rd_sel_hit ?
                     (AXI_DW'(tap_set_q) << TAP_SET_LSB) |
                     (AXI_DW'(src_sel_q) << SRC_SEL_LSB) :        // RL3 RL20
                     rd_run_hit ?
                     (AXI_DW'(run_q) << RUN_STATE_BIT) |           // RL6
                     (AXI_DW'(run_en_q) << RUN_EN_BIT) :           // RL5
                     32'h0000_0000;

    // ----------
    // Write channels: address and data taken in either order
    // ----------
    always_ff @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                awaddr_q  <= s_axi_awaddr_i;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (w_hs)
            begin
                wdata_q  <= s_axi_wdata_i;
                wstrb_q  <= s_axi_wstrb_i;
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (do_wr)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready_i)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ----------
    // Register file
    // ----------
    // Fields outside the masks never store, so they read zero
    always_ff @(posedge clk_sys_i or negedge rst_sync_n)    // RL15
    begin
        if (!rst_sync_n)
        begin
            src_sel_q <= SRC_SEL_RST;                        // RL23
            tap_set_q <= TAP_SET_RST;                        // RL23
            run_en_q  <= RUN_EN_RST;
        end
        else if (do_wr)
        begin
            if (wr_sel_hit && wstrb_q[0])
                src_sel_q <= wdata_q[SRC_SEL_LSB +: SRC_SEL_W] & src_mask;  // RL2 RL21
            if (wr_sel_hit && wstrb_q[1])
                tap_set_q <= wdata_q[TAP_SET_LSB +: TAP_SET_W] & tap_mask;  // RL1 RL4
            if (wr_run_hit && wstrb_q[0])
                run_en_q  <= wdata_q[RUN_EN_BIT];                           // RL6
        end
    end

    // ----------
    // Read channel
    // ----------
    // Answer one cycle after the address is taken
    always_ff @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= (rd_sel_hit | rd_run_hit) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready_i)
        begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ----------
    // Source sampling
    // ----------
    // Index matches the source select code
    assign src_pins = {src_slow_rc_i, src_fast_rc_i, src_main_i, src_sub_i};  // RL12

    wtp_pin_sync #(
        .W         (SRC_N)
    ) u_src_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_sync_n),
        .pin_i     (src_pins),
        .sync_o    (src_sync)
    );

    // Rising edge of the selected source is the divider's clock enable
    always_ff @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            src_prev_q <= '0;
        else
            src_prev_q <= src_sync;
    end

    assign src_edge = src_sync[src_sel_q] & ~src_prev_q[src_sel_q];   // RL2 RL21

    // ----------
    // Enable crossing and divider
    // ----------
    // Enable advances one stage per source edge, so it lands at the second
    always_ff @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            en_pipe_q <= '0;
        else if (src_edge)
            en_pipe_q <= {en_pipe_q[EN_LAT_SRC_CYC-2:0], run_en_q};   // RL16 RL23
    end

    // Run state is the last stage, so both stages carry the enable
    assign run_q = en_pipe_q[EN_LAT_SRC_CYC-1];                       // RL9

    // Down counter, cleared while stopped
    always_ff @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            cnt_q <= '0;
        else if (!run_q)
            cnt_q <= '0;                                   // RL7
        else if (src_edge)
            cnt_q <= cnt_q - CNT_W'(1);                    // RL8 RL13
    end

    // ----------
    // Tick outputs
    // ----------
    wtp_tap_mux u_tap (
        .cnt_i     (cnt_q),
        .tap_set_i (tap_set_q),
        .tick_o    (tick_nxt)
    );

    // Registered ticks, forced low whenever the divider is stopped
    always_ff @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            tick_q <= '0;
        else
            tick_q <= run_q ? tick_nxt : '0;               // RL14 RL7
    end

    // ----------
    // Output assignment
    // ----------
    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o  = wready_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;
    assign {tick_out_3_o, tick_out_2_o, tick_out_1_o, tick_out_0_o} = tick_q;

endmodule // wtp_top

// ---- verification/wtp_watch_model.sv ----
/* Watch counter stand-in: six-bit down count of tick rises.
   Assumes ticks are registered levels on the system clock. */
`timescale 1ns/10ps
module wtp_watch_model (
    input  wire logic       clk_i,   // System clock
    input  wire logic       tick_i,  // Count clock from the prescaler
    input  wire logic       run_i,   // Watch run enable
    output logic      [5:0] cnt_o    // Down count
);
    logic tick_q;
    // Cleared while stopped, counts down on each tick rise
    always_ff @(posedge clk_i) begin
        tick_q <= tick_i;
        cnt_o  <= !run_i ? 6'h0 : cnt_o - {5'h0, tick_i && !tick_q};
    end
endmodule // wtp_watch_model

// ---- verification/wtp_monitor.sv ----
/* Port checker: bus handshakes, reserved read bits and carries between ticks.
   Assumes one clock domain; bound to every prescaler top. */
`timescale 1ns/10ps
module wtp_monitor (
    input wire logic        clk_sys_i, rst_n_i,                // Clock, reset
    input wire logic        s_axi_awvalid_i, s_axi_awready_o,  // Write address
    input wire logic        s_axi_wvalid_i, s_axi_wready_o,    // Write data
    input wire logic        s_axi_bvalid_o, s_axi_bready_i,    // Write response
    input wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o,      // Response codes
    input wire logic        s_axi_arvalid_i, s_axi_arready_o,  // Read address
    input wire logic        s_axi_rvalid_o, s_axi_rready_i,    // Read data
    input wire logic [31:0] s_axi_rdata_o,                     // Read word
    input wire logic        tick_out_0_o, tick_out_1_o,        // Short ticks
    input wire logic        tick_out_2_o, tick_out_3_o         // Long ticks
);
    wire idle = !(tick_out_0_o || tick_out_1_o || tick_out_2_o || tick_out_3_o);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Bus answers come on time and stand until taken
    write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("late write");
    read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("late read");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
    read_single_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("second read taken");
    reserved_zero_a: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'h0
        |-> s_axi_rdata_o[31:11] == 21'h0 && s_axi_rdata_o[7:2] == 6'h0) else $error("reserved set");
    // Ticks 1 and 3 move only on a borrow from the tick below, or when all clear
    carry_one_a: assert property ($changed(tick_out_1_o) |-> $rose(tick_out_0_o) || idle)
        else $error("tick 1 moved alone");
    carry_three_a: assert property ($changed(tick_out_3_o) |-> $rose(tick_out_2_o) || idle)
        else $error("tick 3 moved alone");
    cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
    cover property ($rose(tick_out_3_o));
    cover property (s_axi_rvalid_o && s_axi_rdata_o[1]);
endmodule // wtp_monitor
bind wtp_top wtp_monitor u_mon (.*);

// ---- verification/wtp_top_test.sv ----
/* Prescaler bench, variant B registers, all four sources and tap codes 2, 3, 4 and 7, plus variant A register fields.
   Assumes the bound monitor and the watch model on tick 0. */
`timescale 1ns/10ps
module wtp_top_test;
    import wtp_pkg::*;
    logic        clk_sys_i = 0, rst_n_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic        src_on = 1, run_w = 0, ena = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [3:0]  src = 0;
    logic [1:0]  sel = 0, dv = 0, rsp;
    wire         awr, wrr, bv, arr, rv;
    wire  [1:0]  br, rr;
    wire  [31:0] rdo, rda;
    wire  [3:0]  tk;
    wire  [5:0]  wcnt;
    int          err_count = 0, checks_done = 0, n;
    initial forever #20 clk_sys_i = ~clk_sys_i;
    // Selected source pin toggles every fourth clock while enabled
    always @(posedge clk_sys_i) begin
        dv <= dv + 2'h1;
        if (src_on && dv == 2'h3) src[sel] <= ~src[sel];
    end
    wtp_top #(.VARIANT_B(1'b1)) dut (.clk_sys_i, .rst_n_i, .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rry), .src_sub_i(src[0]), .src_main_i(src[1]), .src_fast_rc_i(src[2]),
        .src_slow_rc_i(src[3]), .tick_out_0_o(tk[0]), .tick_out_1_o(tk[1]),
        .tick_out_2_o(tk[2]), .tick_out_3_o(tk[3]));
    // Variant A copy: shares the bus, writes only while ena is high
    wtp_top dut_a (.clk_sys_i, .rst_n_i, .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv & ena),
        .s_axi_awready_o(), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv & ena),
        .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(bry),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(), .s_axi_rdata_o(rda),
        .s_axi_rresp_o(), .s_axi_rvalid_o(), .s_axi_rready_i(rry), .src_sub_i(src[0]),
        .src_main_i(src[1]), .src_fast_rc_i(src[2]), .src_slow_rc_i(src[3]), .tick_out_0_o(),
        .tick_out_1_o(), .tick_out_2_o(), .tick_out_3_o());
    wtp_watch_model wm (.clk_i(clk_sys_i), .tick_i(tk[0]), .run_i(run_w), .cnt_o(wcnt));
    task automatic check(input string nm, input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin err_count++; $display("[ERR] %s expected %h seen %h", nm, e, g); end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tmo;
        err_count++;
        $display("[ERR] wait expected done seen timeout");
        finish_test;
    endtask
    // Bus cycles: hold each channel until taken, ready held until the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys_i);
            if (awr) awv <= 0;
            if (wrr) wv <= 0;
            if (bv) break;
        end
        bry <= 0; rsp = br;
        if (n == 40) tmo;
        @(posedge clk_sys_i);
    endtask
    task automatic rd_(input logic [7:0] a);
        ara <= a; arv <= 1; rry <= 1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys_i);
            if (arr) arv <= 0;
            if (rv) break;
        end
        rry <= 0; rd = rdo; rsp = rr;
        if (n == 40) tmo;
        @(posedge clk_sys_i);
    endtask
    task automatic run(input logic v);
        wr(OFS_RUN_CTRL, {31'h0, v});
        for (int i = 0; i < 30; i++) begin rd_(OFS_RUN_CTRL); if (rd[1] == v) break; end
        check("run state", {31'h0, rd[1]}, {31'h0, v});
    endtask
    // Source rises between two rises of tick k
    task automatic per(input int k, input int e);
        int c, r; logic pt, ps;
        c = 0; r = 0; pt = 1; ps = 1;
        for (n = 0; n < 12000 && r < 2; n++) begin
            @(posedge clk_sys_i);
            if (tk[k] && !pt) r++;
            if (src[sel] && !ps && r == 1) c++;
            pt = tk[k]; ps = src[sel];
        end
        if (r < 2) tmo;
        check("tick period", c, e);
    endtask
    task automatic t_regs;
        rd_(OFS_SRC_TAP_SEL); check("select reset", rd, 32'h0);
        rd_(OFS_RUN_CTRL); check("control reset", rd, 32'h0);
        wr(OFS_SRC_TAP_SEL, 32'hFFFF_FFFF); rd_(OFS_SRC_TAP_SEL);
        check("select fields", rd, 32'h0000_0703);
        ena <= 1; wr(OFS_SRC_TAP_SEL, 32'hFFFF_F9FF); ena <= 0; rd_(OFS_SRC_TAP_SEL);
        check("select B", rd, 32'h0000_0103);
        check("select A", rda, 32'h0000_0101);
        wr(OFS_RUN_CTRL, 32'h0000_00FE); rd_(OFS_RUN_CTRL);
        check("control ignores", rd, 32'h0);
        wr(8'h08, 32'h1); check("bad write", {30'h0, rsp}, 32'h2);
        rd_(8'h08); check("bad read", {rd[29:0], rsp}, 32'h2);
        $display("register test done");
    endtask
    task automatic t_src;
        for (int s = 0; s < 4; s++) begin
            sel <= 2'(s); wr(OFS_SRC_TAP_SEL, 32'h0000_0200 | s); run(1);
            per(0, 2);
            run(0);
            check("ticks stopped", {28'h0, tk}, 32'h0);
        end
        $display("source test done");
    endtask
    task automatic t_taps;
        sel <= 2'h2; wr(OFS_SRC_TAP_SEL, 32'h0000_0202); run(1);
        for (int k = 0; k < 4; k++) per(k, 2 << k);
        run(0); wr(OFS_SRC_TAP_SEL, 32'h0000_0302); run(1);
        per(3, 256);
        run(0); wr(OFS_SRC_TAP_SEL, 32'h0000_0402); run(1);
        per(0, 512);
        run(0); wr(OFS_SRC_TAP_SEL, 32'h0000_0702); run(1);
        repeat (100) @(posedge clk_sys_i);
        check("unused code ticks", {28'h0, tk}, 32'h0);
        run(0); wr(OFS_SRC_TAP_SEL, 32'h0000_0202);
        $display("tap test done");
    endtask
    // Enable waits for source edges; then the watch counter is restarted
    task automatic t_still;
        src_on <= 0; wr(OFS_RUN_CTRL, 32'h0000_0001);
        repeat (60) @(posedge clk_sys_i);
        rd_(OFS_RUN_CTRL); check("run while still", rd, 32'h0000_0001);
        check("ticks while still", {28'h0, tk}, 32'h0);
        src_on <= 1; run(1);
        run_w <= 0; repeat (2) @(posedge clk_sys_i);
        check("watch cleared", {26'h0, wcnt}, 32'h0);
        run_w <= 1; per(0, 2);
        check("watch counts", {31'h0, wcnt != 6'h0}, 32'h1);
        run_w <= 0; run(0);
        $display("restart test done");
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1;
        repeat (4) @(posedge clk_sys_i);
        t_regs; t_src; t_taps; t_still;
        finish_test;
    end
endmodule // wtp_top_test
